//--- rtl/pbp_cfg.svh
// Purpose: Offsets, reset values, field positions and codes for the port.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Definitions only, no logic.
`ifndef PBP_CFG_SVH
`define PBP_CFG_SVH

// Register word indices
`define PBP_IDX_DIR     16'hFFD4
`define PBP_IDX_DATA    16'hFFD6
`define PBP_IDX_SHARE   16'hFFD8

// Reset values and fixed read values
`define PBP_DIR_RST     8'h00
`define PBP_DATA_RST    8'h00
`define PBP_SHARE_RST   4'h0
`define PBP_DIR_READ    8'hFF

// Pin-sharing register field positions
`define PBP_BIT_TRIG_EN 0
`define PBP_BIT_OUTA_EN 1
`define PBP_BIT_OUTB_EN 2
`define PBP_BIT_COMB    3

// Pins with a shared function
`define PBP_PIN_TRIG    7
`define PBP_PIN_OUTB    5
`define PBP_PIN_OUTA    4

// Bus response codes
`define PBP_RESP_OKAY   2'h0
`define PBP_RESP_SLVERR 2'h2

`endif

//--- rtl/pbp_pkg.sv
// Purpose: Shared types of the eight-bit port.
// Assumes: Constants live in pbp_cfg.svh.
// Notes:   Types only.
package pbp_pkg;

  typedef logic [7:0] pbp_byte_t;
  typedef logic [3:0] pbp_share_t;
  typedef logic [1:0] pbp_resp_t;

endpackage : pbp_pkg

//--- rtl/pbp_axil.sv
// Purpose: AXI4-Lite slave front end; one write and one read at a time.
// Assumes: Decode and read data come from the owner on the same clock.
// Notes:   Address and data are taken in either order.
`timescale 1ns/1ps
`include "pbp_cfg.svh"
module pbp_axil
  import pbp_pkg::*;
#(
  parameter int ADDR_W = 18
)(
  input  wire logic              clk,      // System clock
  input  wire logic              srst,     // Sync reset, high
  input  wire logic              ce,       // Clock enable
  input  wire logic [ADDR_W-1:0] awaddr,   // Write address
  input  wire logic              awvalid,  // Write address valid
  output logic                   awready,  // Write address ready
  input  wire logic [31:0]       wdata,    // Write data
  input  wire logic [3:0]        wstrb,    // Write strobes
  input  wire logic              wvalid,   // Write data valid
  output logic                   wready,   // Write data ready
  output logic [1:0]             bresp,    // Write response
  output logic                   bvalid,   // Write response valid
  input  wire logic              bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,   // Read address
  input  wire logic              arvalid,  // Read address valid
  output logic                   arready,  // Read address ready
  output logic [31:0]            rdata,    // Read data
  output logic [1:0]             rresp,    // Read response
  output logic                   rvalid,   // Read data valid
  input  wire logic              rready,   // Read data ready
  output logic                   wr_en,    // Write strobe to owner
  output logic [ADDR_W-1:0]      wr_addr,  // Write address to owner
  output logic [31:0]            wr_data,  // Write data to owner
  output logic [3:0]             wr_strb,  // Write strobes to owner
  input  wire logic              wr_ok,    // Write address mapped
  output logic                   rd_en,    // Read strobe to owner
  output logic [ADDR_W-1:0]      rd_addr,  // Read address to owner
  input  wire logic [31:0]       rd_data,  // Read data from owner
  input  wire logic              rd_ok     // Read address mapped
);

  typedef struct packed {
    logic              aw_rdy;
    logic              w_rdy;
    logic              ar_rdy;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    pbp_resp_t         bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    pbp_resp_t         rresp;
  } pbp_axil_state_t;

  localparam pbp_axil_state_t AXIL_RST = '{
    aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};

  pbp_axil_state_t st_reg;
  pbp_axil_state_t st_next;

  // Strobes to the owner; held low when the clock enable is low
  assign wr_en   = ce && st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign wr_addr = st_reg.awaddr;
  assign wr_data = st_reg.wdata;
  assign wr_strb = st_reg.wstrb;
  assign rd_en   = ce && arvalid && st_reg.ar_rdy;
  assign rd_addr = araddr;

  // Channel handshakes; ready drops so only one of each is in flight
  always_comb
  begin
    st_next = st_reg;
    if (awvalid && st_reg.aw_rdy)
    begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = awaddr;
      st_next.aw_rdy = 1'b0;
    end
    if (wvalid && st_reg.w_rdy)
    begin
      st_next.w_got  = 1'b1;
      st_next.wdata  = wdata;
      st_next.wstrb  = wstrb;
      st_next.w_rdy  = 1'b0;
    end
    if (wr_en)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_ok ? `PBP_RESP_OKAY : `PBP_RESP_SLVERR;
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
    end
    if (st_reg.bvalid && bready)
    begin
      st_next.bvalid = 1'b0;
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy  = 1'b1;
    end
    if (rd_en)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_ok ? rd_data : 32'h00000000;
      st_next.rresp  = rd_ok ? `PBP_RESP_OKAY : `PBP_RESP_SLVERR;
      st_next.ar_rdy = 1'b0;
    end
    if (st_reg.rvalid && rready)
    begin
      st_next.rvalid = 1'b0;
      st_next.ar_rdy = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
      st_reg <= AXIL_RST;
    else if (ce)
      st_reg <= st_next;
  end

  assign awready = st_reg.aw_rdy;
  assign wready  = st_reg.w_rdy;
  assign bvalid  = st_reg.bvalid;
  assign bresp   = st_reg.bresp;
  assign arready = st_reg.ar_rdy;
  assign rvalid  = st_reg.rvalid;
  assign rdata   = st_reg.rdata;
  assign rresp   = st_reg.rresp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_wr_pair;
    ce && st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  endsequence
  sequence s_rd_take;
    ce && arvalid && arready;
  endsequence

  a_write_answer: assert property (s_wr_pair |=> bvalid && !awready)
    else $error("write pair not answered");
  a_read_answer: assert property (s_rd_take |=> rvalid && !arready)
    else $error("read not answered");
  a_bresp_held: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");

endmodule : pbp_axil

//--- rtl/pbp_port.sv
// Purpose: Eight-bit port with direction and data registers, pin sharing.
// Assumes: Timer outputs and standby request come from logic on CLK.
// Notes:   Pins and hardware standby are synchronised by two flops.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pbp_cfg.svh"
module pbp_port
  import pbp_pkg::*;
#(
  parameter int ADDR_W = 18
)(
  input  wire logic              CLK,                     // 200 MHz clock
  input  wire logic              SRST,                    // Sync reset
  input  wire logic              CE,                      // Clock enable
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,            // Write addr
  input  wire logic [2:0]        S_AXI_AWPROT,            // Unused
  input  wire logic              S_AXI_AWVALID,           // Addr valid
  output logic                   S_AXI_AWREADY,           // Addr ready
  input  wire logic [31:0]       S_AXI_WDATA,             // Write data
  input  wire logic [3:0]        S_AXI_WSTRB,             // Byte strobes
  input  wire logic              S_AXI_WVALID,            // Data valid
  output logic                   S_AXI_WREADY,            // Data ready
  output logic [1:0]             S_AXI_BRESP,             // Write resp
  output logic                   S_AXI_BVALID,            // Resp valid
  input  wire logic              S_AXI_BREADY,            // Resp ready
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,            // Read addr
  input  wire logic [2:0]        S_AXI_ARPROT,            // Unused
  input  wire logic              S_AXI_ARVALID,           // Addr valid
  output logic                   S_AXI_ARREADY,           // Addr ready
  output logic [31:0]            S_AXI_RDATA,             // Read data
  output logic [1:0]             S_AXI_RRESP,             // Read resp
  output logic                   S_AXI_RVALID,            // Data valid
  input  wire logic              S_AXI_RREADY,            // Data ready
  input  wire logic [7:0]        PIN_IN,                  // Pin levels
  output logic [7:0]             PIN_OUT,                 // Pin drive level
  output logic [7:0]             PIN_OE,                  // Pin drive enable
  input  wire logic              HW_STANDBY,              // Pin, async
  input  wire logic              SW_STANDBY,              // Standby, CLK
  input  wire logic              CH4_COMPLEMENTARY_OUT_A, // Timer out A
  input  wire logic              CH4_COMPLEMENTARY_OUT_B, // Timer out B
  output logic                   CONVERTER_EXT_TRIGGER_N  // Trigger, low
);

  typedef struct packed {
    pbp_byte_t  dir;
    pbp_byte_t  data;
    pbp_share_t share;
    pbp_byte_t  pin_s1;
    pbp_byte_t  pin_s2;
    logic       hws1;
    logic       hws2;
    pbp_byte_t  pin_out;
    pbp_byte_t  pin_oe;
    logic       trig_n;
  } pbp_port_state_t;

  localparam pbp_port_state_t PORT_RST = '{
    dir:    `PBP_DIR_RST,
    data:   `PBP_DATA_RST,
    share:  `PBP_SHARE_RST,
    trig_n: 1'b1,
    default: '0};

  pbp_port_state_t st_reg;
  pbp_port_state_t st_next;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic              wr_allowed;

  // Word decode; the two low address bits are ignored
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [15:0]       idx);
    addr_hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction : addr_hit

  // Port value as software sees it, per pin by direction
  function automatic pbp_byte_t port_view(input pbp_byte_t dir,
                                          input pbp_byte_t data,
                                          input pbp_byte_t pins);
    port_view = (dir & data) | (~dir & pins);
  endfunction : port_view

  pbp_axil #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .clk     (CLK),
    .srst    (SRST),
    .ce      (CE),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Write decode; unmapped addresses answer with an error response
  assign wr_ok = addr_hit(wr_addr, `PBP_IDX_DIR)
              || addr_hit(wr_addr, `PBP_IDX_DATA)
              || addr_hit(wr_addr, `PBP_IDX_SHARE);

  // Writes in software standby are answered but not stored
  assign wr_allowed = wr_en && wr_strb[0] && !SW_STANDBY && !st_reg.hws2;

  // Read mux
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_data = 32'h00000000;
    if (addr_hit(rd_addr, `PBP_IDX_DIR))
      rd_data[7:0] = `PBP_DIR_READ;
    else if (addr_hit(rd_addr, `PBP_IDX_DATA))
      rd_data[7:0] = port_view(st_reg.dir, st_reg.data,
                               st_reg.pin_s2);
    else if (addr_hit(rd_addr, `PBP_IDX_SHARE))
      rd_data[3:0] = st_reg.share;
    else
      rd_ok = 1'b0;
  end

  // Next state: synchronisers, registers, pin drive, trigger
  always_comb
  begin
    st_next        = st_reg;
    st_next.pin_s1 = PIN_IN;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.hws1   = HW_STANDBY;
    st_next.hws2   = st_reg.hws1;

    // Hardware standby clears like reset; software standby keeps all
    if (st_reg.hws2)
    begin
      st_next.dir   = `PBP_DIR_RST;
      st_next.data  = `PBP_DATA_RST;
      st_next.share = `PBP_SHARE_RST;
    end
    else if (wr_allowed)
    begin
      if (addr_hit(wr_addr, `PBP_IDX_DIR))
        st_next.dir = wr_data[7:0];
      if (addr_hit(wr_addr, `PBP_IDX_DATA))
        st_next.data = wr_data[7:0];
      if (addr_hit(wr_addr, `PBP_IDX_SHARE))
        st_next.share = wr_data[3:0];
    end

    // Pin drive; no chip mode input, so the mux is the same in all modes
    if (st_reg.hws2)
    begin
      st_next.pin_oe  = 8'h00;
      st_next.pin_out = 8'h00;
    end
    else if (!SW_STANDBY)
    begin
      st_next.pin_oe  = st_reg.dir;
      st_next.pin_out = st_reg.data;
      if (st_reg.share[`PBP_BIT_OUTB_EN] && st_reg.share[`PBP_BIT_COMB])
      begin
        st_next.pin_oe[`PBP_PIN_OUTB]  = 1'b1;
        st_next.pin_out[`PBP_PIN_OUTB] = CH4_COMPLEMENTARY_OUT_B;
      end
      if (st_reg.share[`PBP_BIT_OUTA_EN] && st_reg.share[`PBP_BIT_COMB])
      begin
        st_next.pin_oe[`PBP_PIN_OUTA]  = 1'b1;
        st_next.pin_out[`PBP_PIN_OUTA] = CH4_COMPLEMENTARY_OUT_A;
      end
    end

    // Trigger sees the pin level whatever the pin direction
    if (st_reg.share[`PBP_BIT_TRIG_EN])
      st_next.trig_n = st_reg.pin_s2[`PBP_PIN_TRIG];
    else
      st_next.trig_n = 1'b1;
  end

  // State register; reset acts even while the clock enable is low
  always_ff @(posedge CLK)
  begin
    if (SRST)
      st_reg <= PORT_RST;
    else if (CE)
      st_reg <= st_next;
  end

  assign PIN_OUT                 = st_reg.pin_out;
  assign PIN_OE                  = st_reg.pin_oe;
  assign CONVERTER_EXT_TRIGGER_N = st_reg.trig_n;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_rd_data;
    rd_en && addr_hit(rd_addr, `PBP_IDX_DATA);
  endsequence

  sequence s_free_run;
    CE && !SW_STANDBY && !st_reg.hws2;
  endsequence

  a_dir_reads_ones: assert property (
    rd_en && addr_hit(rd_addr, `PBP_IDX_DIR)
    |=> S_AXI_RDATA == 32'h000000FF && S_AXI_RVALID)
    else $error("direction read not all ones");

  a_reset_clears: assert property (
    disable iff (1'b0)
    SRST |=> st_reg.dir == 8'h00 && st_reg.data == 8'h00)
    else $error("reset did not clear registers");

  a_hwstby_dir_clear: assert property (
    CE && st_reg.hws2 |=> st_reg.dir == 8'h00 && PIN_OE == 8'h00)
    else $error("hardware standby did not clear direction");

  a_swstby_holds: assert property (
    CE && SW_STANDBY && !st_reg.hws2
    |=> $stable(st_reg.dir) && $stable(st_reg.data)
        && $stable(PIN_OUT) && $stable(PIN_OE))
    else $error("software standby changed port state");

  a_read_out_bits: assert property (
    s_rd_data |=> (S_AXI_RDATA[7:0] & $past(st_reg.dir))
                  == ($past(st_reg.data) & $past(st_reg.dir)))
    else $error("output pin read not stored bit");

  a_read_in_bits: assert property (
    s_rd_data |=> (S_AXI_RDATA[7:0] & ~$past(st_reg.dir))
                  == ($past(st_reg.pin_s2) & ~$past(st_reg.dir)))
    else $error("input pin read not pin level");

  a_hwstby_data_clear: assert property (
    CE && st_reg.hws2 |=> st_reg.data == 8'h00)
    else $error("hardware standby did not clear data");

  a_data_write_kept: assert property (
    CE && wr_allowed && addr_hit(wr_addr, `PBP_IDX_DATA)
    |=> st_reg.data == $past(wr_data[7:0]) && S_AXI_BVALID)
    else $error("data write not stored or answered");

  a_trig_follows: assert property (
    CE && st_reg.share[`PBP_BIT_TRIG_EN]
    |=> CONVERTER_EXT_TRIGGER_N == $past(st_reg.pin_s2[`PBP_PIN_TRIG]))
    else $error("trigger does not follow pin 7");

  a_pin5_timer: assert property (
    s_free_run and (st_reg.share[`PBP_BIT_OUTB_EN]
                    && st_reg.share[`PBP_BIT_COMB])
    |=> PIN_OE[5] && PIN_OUT[5] == $past(CH4_COMPLEMENTARY_OUT_B))
    else $error("pin 5 not timer output");

  a_pin4_timer: assert property (
    s_free_run and (st_reg.share[`PBP_BIT_OUTA_EN]
                    && st_reg.share[`PBP_BIT_COMB])
    |=> PIN_OE[4] && PIN_OUT[4] == $past(CH4_COMPLEMENTARY_OUT_A))
    else $error("pin 4 not timer output");

  a_plain_dir: assert property (
    s_free_run |=> (PIN_OE & 8'hCF) == ($past(st_reg.dir) & 8'hCF))
    else $error("pin drive does not follow direction");

  // Drive level tracks every stored bit, inputs too, so a later
  // direction change drives what software wrote earlier
  a_input_write: assert property (
    s_free_run and (st_reg.share == 4'h0)
    |=> PIN_OUT == $past(st_reg.data))
    else $error("stored bit not on pin drive level");

endmodule : pbp_port

//--- verification/pbp_board.sv
// Purpose: Board-side model of the eight port pins.
// Assumes: The board applies its own level wherever the port is silent.
// Notes:   No pulls; a released pin shows the level the bench commands.
`timescale 1ns/1ps
module pbp_board
(
  input  wire logic [7:0] pin_out, // Port drive level
  input  wire logic [7:0] pin_oe,  // Port drive enable
  input  wire logic [7:0] ext_lvl, // Level the board applies
  output logic      [7:0] pin_lvl  // Resolved pin level
);
  // Port wins where it drives, so the two sides never fight
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule : pbp_board

//--- verification/testbench.sv
// Purpose: Self-checking bench for the eight-bit port.
// Assumes: Integer model of the registers is compared at every result.
// Notes:   Pins are checked four cycles after a change to clear the sync.
`timescale 1ns/1ps
`include "pbp_cfg.svh"
module testbench
  import pbp_pkg::*;
;
  logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        hw_sb, sw_sb, tmr_a, tmr_b, trig_n, ce;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  pin_in, pin_out, pin_oe, ext;
  int          n_errors, check_count, dir_m, dat_m, shr_m;

  // Clock at 200 MHz
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  pbp_port #(.ADDR_W(18)) uut (
    .CLK(clk), .SRST(srst), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .HW_STANDBY(hw_sb),
    .SW_STANDBY(sw_sb), .CH4_COMPLEMENTARY_OUT_A(tmr_a),
    .CH4_COMPLEMENTARY_OUT_B(tmr_b), .CONVERTER_EXT_TRIGGER_N(trig_n));

  pbp_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext),
    .pin_lvl(pin_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] idx);
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Write through the bus and mirror it in the model
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bit mapped;
    mapped = idx == `PBP_IDX_DIR || idx == `PBP_IDX_DATA
             || idx == `PBP_IDX_SHARE;
    axi_wr(idx, d);
    chk(rsp, mapped ? `PBP_RESP_OKAY : `PBP_RESP_SLVERR);
    if (!sw_sb && !hw_sb && wstrb[0])
    begin
      if (idx == `PBP_IDX_DIR) dir_m = d[7:0];
      if (idx == `PBP_IDX_DATA) dat_m = d[7:0];
      if (idx == `PBP_IDX_SHARE) shr_m = d[3:0];
    end
  endtask : wr

  function automatic logic [7:0] e_oe();
    return dir_m[7:0] | {2'b00, shr_m[2] & shr_m[3], shr_m[1] & shr_m[3],
                         4'h0};
  endfunction : e_oe

  function automatic logic [7:0] e_out();
    logic [7:0] o;
    o = dat_m[7:0];
    if (shr_m[1] && shr_m[3]) o[4] = tmr_a;
    if (shr_m[2] && shr_m[3]) o[5] = tmr_b;
    return o;
  endfunction : e_out

  // Pins settle, then drive, trigger and both reads are compared
  task automatic check_pins();
    logic [7:0] lvl, dir;
    repeat (4) @(posedge clk);
    #1;
    dir = dir_m[7:0];
    lvl = (e_oe() & e_out()) | (~e_oe() & ext);
    chk(pin_oe, e_oe());
    chk(pin_out & e_oe(), e_out() & e_oe());
    chk(trig_n, shr_m[0] ? lvl[7] : 1'b1);
    axi_rd(`PBP_IDX_DATA);
    chk(rd, {24'h0, (dir & dat_m[7:0]) | (~dir & lvl)});
    axi_rd(`PBP_IDX_DIR);
    chk(rd, 32'h0000_00FF);
  endtask : check_pins

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, hw_sb, sw_sb} = '0;
    {tmr_a, tmr_b, awaddr, araddr, wdata, ext} = '0;
    {n_errors, check_count, dir_m, dat_m, shr_m} = '0;
    wstrb = 4'hF;
    ce = 1'b1;
    srst = 1'b1;
    void'($urandom(62));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    check_pins();
    // Random direction and data mixes with random board levels
    repeat (12)
    begin
      wr(`PBP_IDX_DATA, $urandom());
      wr(`PBP_IDX_DIR, $urandom());
      ext <= 8'($urandom());
      check_pins();
    end
    // Data stored while input, then driven once direction is set
    wr(`PBP_IDX_DIR, 32'h0);
    wr(`PBP_IDX_DATA, 32'hA5);
    wr(`PBP_IDX_DIR, 32'hFF);
    // Low byte strobe off: answered, nothing stored
    wstrb <= 4'hE;
    wr(`PBP_IDX_DATA, 32'h5A);
    wstrb <= 4'hF;
    check_pins();
    chk(pin_out, 8'hA5);
    axi_rd(16'h0040);
    chk(rsp, `PBP_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(16'h0040, 32'h55);
    // Every sharing combination with random timer levels
    wr(`PBP_IDX_DIR, 32'h0);
    for (int s = 0; s < 16; s++)
    begin
      wr(`PBP_IDX_SHARE, s);
      tmr_a <= 1'($urandom());
      tmr_b <= 1'($urandom());
      ext <= 8'($urandom());
      check_pins();
    end
    wr(`PBP_IDX_SHARE, 32'h0);
    // Software standby keeps registers and driven levels
    wr(`PBP_IDX_DIR, 32'h0F);
    wr(`PBP_IDX_DATA, 32'h3C);
    sw_sb <= 1'b1;
    wr(`PBP_IDX_DIR, 32'hF0);
    wr(`PBP_IDX_DATA, 32'hC3);
    check_pins();
    sw_sb <= 1'b0;
    // Clock enable low freezes the port, even against hardware standby
    ce    <= 1'b0;
    hw_sb <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(pin_oe, e_oe());
    ce <= 1'b1;
    // Hardware standby clears everything and floats the pins
    repeat (5) @(posedge clk);
    #1;
    chk(pin_oe, 8'h00);
    hw_sb <= 1'b0;
    {dir_m, dat_m, shr_m} = '0;
    check_pins();
    wr(`PBP_IDX_DIR, 32'hFF);
    check_pins();
    report_and_stop();
  end
endmodule : testbench
